// [rtl/nftf_frame_timing.sv]
// Frame configuration, reply-delay timing and status registers of the tag front end
// What this block does
// [R01] Read-only view of load modulation drive
// [R02] Field-present bit, valid when activated
// [R03] Receiver-locked status bit
// [R04] Minimum delay in carrier clocks, reset 0x480
// [R05] Maximum delay in carrier clocks, reset 0x1000
// [R06] Mode 0 sends at once, no timeout
// [R07] Mode 1 sends within min/max window
// [R08] Mode 2 sends exactly at maximum
// [R09] Mode 3 sends on bit grid in window
// [R10] One byte pointer for both directions
// [R11] Buffer size limited to 0..257
// [R12] Transmit bit 0 adds parity
// [R13] Transmit bit 1 picks drop side
// [R14] Transmit bit 2 adds start symbol
// [R15] Transmit bit 4 appends 16-bit check
// [R16] Receive bit 0 expects parity
// [R17] Receive bit 2 expects start symbol
// [R18] Receive bit 4 checks final 16 bits
// [R19] Final id bytes, reset 0x6363
// [R20] Middle id bytes in bits 23:0
// [R21] Id length code 0,1,2
// [R22] Check-failed flag set on mismatch
// [R23] Overrun flag, write one clears
// [R24] Transmit bytes 11:3, bits 2:0
// [R25] Report received bytes and leftover bits
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "nftf_params.svh"
module nftf_frame_timing #(
    parameter int AW = 12
) (
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic [AW-1:0] addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          wr_stb,
    input  wire logic          rd_stb,
    output logic      [31:0]   rdata,
    input  wire logic          carrier_clk,
    input  wire logic          field_pin,
    input  wire logic          lock_pin,
    input  wire logic          activated,
    input  wire logic [4:0]    load_control_in,
    input  wire logic          transmit_start_task,
    input  wire logic          rx_frame_done,
    input  wire logic [8:0]    rx_whole_bytes,
    input  wire logic [2:0]    rx_leftover_bits,
    input  wire logic          rx_check_bad,
    input  wire logic          rx_overrun,
    output logic               tx_go,
    output logic               delay_timeout,
    output logic               tx_add_parity,
    output logic               unused_bit_drop_side,
    output logic               tx_add_sof,
    output logic               transmit_check_append,
    output logic               rx_expect_parity,
    output logic               rx_expect_sof,
    output logic               receive_check_verify,
    output logic [1:0]         tag_id_length,
    output logic [31:0]        frame_buffer_pointer,
    output logic [8:0]         frame_buffer_size
);
    // Pin inputs cross into mclk
    logic [3:0] pins_s;
    nftf_sync #(.W(4)) u_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   ({carrier_clk, field_pin, lock_pin, activated}),
        .dout  (pins_s)
    );
    logic carrier_d_r;
    wire  carrier_tick = pins_s[3] & ~carrier_d_r;

    logic [31:0]             reply_delay_minimum_r;
    logic [31:0]             reply_delay_maximum_r;
    nftf_pkg::nftf_mode_t    reply_delay_mode_r;
    logic [31:0]             ptr_r;
    logic [8:0]              size_r;
    logic [4:0]              txopt_r;
    logic [11:0]             txlen_r;
    logic [4:0]              rxopt_r;
    logic [11:0]             rxlen_r;
    logic [31:0]             id_final_r;
    logic [23:0]             id_mid_r;
    logic [1:0]              id_len_r;
    logic                    crc_fail_r;
    logic                    overrun_r;
    nftf_pkg::nftf_state_t   state_r;
    nftf_pkg::nftf_state_t   state_nxt;
    logic [31:0]             dcount_r;
    logic                    pend_r;

    function automatic logic hit(input logic [AW-1:0] a, input logic [11:0] ofs);
        hit = (a == AW'(ofs));
    endfunction

    wire w_min  = wr_stb & hit(addr, `NFTF_OFS_DLYMIN);
    wire w_max  = wr_stb & hit(addr, `NFTF_OFS_DLYMAX);
    wire w_mode = wr_stb & hit(addr, `NFTF_OFS_DLYMODE);
    wire w_ptr  = wr_stb & hit(addr, `NFTF_OFS_PTR);
    wire w_size = wr_stb & hit(addr, `NFTF_OFS_BUFSIZE);
    wire w_txo  = wr_stb & hit(addr, `NFTF_OFS_TXOPT);
    wire w_txl  = wr_stb & hit(addr, `NFTF_OFS_TXLEN);
    wire w_rxo  = wr_stb & hit(addr, `NFTF_OFS_RXOPT);
    wire w_idf  = wr_stb & hit(addr, `NFTF_OFS_IDFINAL);
    wire w_idm  = wr_stb & hit(addr, `NFTF_OFS_IDMID);
    wire w_idl  = wr_stb & hit(addr, `NFTF_OFS_IDLEN);
    wire w_rxs  = wr_stb & hit(addr, `NFTF_OFS_RXSTAT);

    // Oversized buffer writes saturate at the top of range
    wire [8:0] size_wr = (wdata[31:9] != 23'h0 || wdata[8:0] > `NFTF_BUFSIZE_MAX) ?
                         `NFTF_BUFSIZE_MAX : wdata[8:0]; // see [R11]
    wire [1:0] idl_wr  = (wdata[1:0] == 2'h3) ? 2'h2 : wdata[1:0]; // see [R21]

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            reply_delay_minimum_r <= `NFTF_RST_DLYMIN; // see [R04]
            reply_delay_maximum_r <= `NFTF_RST_DLYMAX; // see [R05]
            reply_delay_mode_r    <= nftf_pkg::NFTF_WINDOW_SEND; // see [R07]
            ptr_r                 <= 32'h0;
            size_r                <= 9'h0;
            txopt_r               <= `NFTF_RST_TXOPT;
            txlen_r               <= 12'h0;
            rxopt_r               <= `NFTF_RST_RXOPT;
            id_final_r            <= `NFTF_RST_IDFINAL; // see [R19]
            id_mid_r              <= 24'h0;
            id_len_r              <= 2'h0;
        end
        else
        begin
            if (w_min)  reply_delay_minimum_r <= wdata;
            if (w_max)  reply_delay_maximum_r <= wdata;
            if (w_mode) reply_delay_mode_r <= nftf_pkg::nftf_mode_t'(wdata[1:0]);
            if (w_ptr)  ptr_r <= wdata; // see [R10]
            if (w_size) size_r <= size_wr;
            if (w_txo)  txopt_r <= {wdata[4], 1'b0, wdata[2:0]};
            if (w_txl)  txlen_r <= wdata[11:0]; // see [R24]
            if (w_rxo)  rxopt_r <= {wdata[4], 1'b0, wdata[2], 1'b0, wdata[0]};
            if (w_idf)  id_final_r <= wdata;
            if (w_idm)  id_mid_r <= wdata[23:0]; // see [R20]
            if (w_idl)  id_len_r <= idl_wr;
        end
    end

    // Receive result: hardware set beats software clear
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            crc_fail_r <= 1'b0;
            overrun_r  <= 1'b0;
            rxlen_r    <= 12'h0;
        end
        else
        begin
            if (rx_frame_done)
                rxlen_r <= {rx_whole_bytes, rx_leftover_bits}; // see [R25]
            if (rx_frame_done && rxopt_r[`NFTF_BIT_CHECK])
                crc_fail_r <= rx_check_bad; // see [R18] [R22]
            else if (w_rxs && wdata[`NFTF_BIT_CRCFAIL])
                crc_fail_r <= 1'b0;
            if (rx_overrun)
                overrun_r <= 1'b1; // see [R23]
            else if (w_rxs && wdata[`NFTF_BIT_OVERRUN])
                overrun_r <= 1'b0;
        end
    end

    // Reply-delay timer counts carrier clocks since the start task
    wire above_min = dcount_r >= reply_delay_minimum_r;
    wire at_max    = dcount_r >= reply_delay_maximum_r;
    wire on_grid   = (dcount_r[6:0] == 7'h0);
    logic send_now;
    always_comb
    begin
        case (reply_delay_mode_r)
            nftf_pkg::NFTF_IMMEDIATE_SEND:  send_now = 1'b1; // see [R06]
            nftf_pkg::NFTF_WINDOW_SEND:     send_now = above_min; // see [R07]
            nftf_pkg::NFTF_SEND_AT_MAXIMUM: send_now = at_max; // see [R08]
            nftf_pkg::NFTF_SEND_ON_BIT_GRID: send_now = above_min & on_grid; // see [R09]
            default:                        send_now = 1'b0;
        endcase
    end
    wire immediate = (reply_delay_mode_r == nftf_pkg::NFTF_IMMEDIATE_SEND);
    wire window_over = carrier_tick & at_max & ~immediate;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            nftf_pkg::NFTF_IDLE:
                if (transmit_start_task)
                    state_nxt = immediate ? nftf_pkg::NFTF_SEND : nftf_pkg::NFTF_WAIT;
            nftf_pkg::NFTF_WAIT:
                if (pend_r && send_now)
                    state_nxt = nftf_pkg::NFTF_SEND;
                else if (window_over)
                    state_nxt = nftf_pkg::NFTF_IDLE;
            nftf_pkg::NFTF_SEND:
                state_nxt = nftf_pkg::NFTF_IDLE;
            default:
                state_nxt = nftf_pkg::NFTF_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_r     <= nftf_pkg::NFTF_IDLE;
            dcount_r    <= 32'h0;
            pend_r      <= 1'b0;
            carrier_d_r <= 1'b0;
        end
        else
        begin
            carrier_d_r <= pins_s[3];
            state_r     <= state_nxt;
            if (state_r == nftf_pkg::NFTF_IDLE)
                dcount_r <= 32'h0;
            else if (carrier_tick)
                dcount_r <= dcount_r + 32'h1;
            pend_r <= (state_r == nftf_pkg::NFTF_WAIT) & carrier_tick;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            tx_go         <= 1'b0;
            delay_timeout <= 1'b0;
        end
        else
        begin
            tx_go         <= (state_nxt == nftf_pkg::NFTF_SEND);
            delay_timeout <= (state_r == nftf_pkg::NFTF_WAIT) &&
                             (state_nxt == nftf_pkg::NFTF_IDLE);
        end
    end

    assign tx_add_parity         = txopt_r[`NFTF_BIT_PARITY]; // see [R12]
    assign unused_bit_drop_side  = txopt_r[`NFTF_BIT_DROPSIDE]; // see [R13]
    assign tx_add_sof            = txopt_r[`NFTF_BIT_SOF]; // see [R14]
    assign transmit_check_append = txopt_r[`NFTF_BIT_CHECK]; // see [R15]
    assign rx_expect_parity      = rxopt_r[`NFTF_BIT_PARITY]; // see [R16]
    assign rx_expect_sof         = rxopt_r[`NFTF_BIT_SOF]; // see [R17]
    assign receive_check_verify  = rxopt_r[`NFTF_BIT_CHECK];
    assign tag_id_length         = id_len_r;
    assign frame_buffer_pointer  = ptr_r;
    assign frame_buffer_size     = size_r;

    // Field bit reads zero outside the activated state
    wire [31:0] field_word = {30'h0, pins_s[1], pins_s[2] & pins_s[0]}; // see [R02] [R03]
    logic [31:0] rd_mux;
    always_comb
    begin
        case (addr)
            AW'(`NFTF_OFS_LOADCTRL): rd_mux = {27'h0, load_control_in}; // see [R01]
            AW'(`NFTF_OFS_FIELD):    rd_mux = field_word;
            AW'(`NFTF_OFS_RXSTAT):   rd_mux = {29'h0, overrun_r, 1'b0, crc_fail_r};
            AW'(`NFTF_OFS_DLYMIN):   rd_mux = reply_delay_minimum_r;
            AW'(`NFTF_OFS_DLYMAX):   rd_mux = reply_delay_maximum_r;
            AW'(`NFTF_OFS_DLYMODE):  rd_mux = {30'h0, reply_delay_mode_r};
            AW'(`NFTF_OFS_PTR):      rd_mux = ptr_r;
            AW'(`NFTF_OFS_BUFSIZE):  rd_mux = {23'h0, size_r};
            AW'(`NFTF_OFS_TXOPT):    rd_mux = {27'h0, txopt_r};
            AW'(`NFTF_OFS_TXLEN):    rd_mux = {20'h0, txlen_r};
            AW'(`NFTF_OFS_RXOPT):    rd_mux = {27'h0, rxopt_r};
            AW'(`NFTF_OFS_RXLEN):    rd_mux = {20'h0, rxlen_r};
            AW'(`NFTF_OFS_IDFINAL):  rd_mux = id_final_r;
            AW'(`NFTF_OFS_IDMID):    rd_mux = {8'h0, id_mid_r};
            AW'(`NFTF_OFS_IDLEN):    rd_mux = {30'h0, id_len_r};
            AW'(`NFTF_OFS_CTRL):     rd_mux = {29'h0, state_r};
            default:                 rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            rdata <= 32'h0;
        else if (rd_stb)
            rdata <= rd_mux;
        else
            rdata <= 32'h0;
    end

    // Checks
    sequence s_start_wait;
        (state_r == nftf_pkg::NFTF_IDLE) && transmit_start_task && !immediate;
    endsequence

    a_immediate_send: assert property (@(posedge mclk) disable iff (!rst_b) // see [R06]
        (state_r == nftf_pkg::NFTF_IDLE) && transmit_start_task && immediate |=> tx_go)
        else $error("immediate mode did not send next cycle");
    a_window_not_early: assert property (@(posedge mclk) disable iff (!rst_b) // see [R07]
        tx_go && reply_delay_mode_r == nftf_pkg::NFTF_WINDOW_SEND |->
        $past(dcount_r) >= reply_delay_minimum_r)
        else $error("window send before minimum");
    a_exact_max: assert property (@(posedge mclk) disable iff (!rst_b) // see [R08]
        tx_go && reply_delay_mode_r == nftf_pkg::NFTF_SEND_AT_MAXIMUM |->
        $past(dcount_r) >= reply_delay_maximum_r)
        else $error("exact mode sent before maximum");
    a_grid_aligned: assert property (@(posedge mclk) disable iff (!rst_b) // see [R09]
        tx_go && reply_delay_mode_r == nftf_pkg::NFTF_SEND_ON_BIT_GRID |->
        $past(dcount_r[6:0]) == 7'h0)
        else $error("grid send off grid");
    a_wait_entered: assert property (@(posedge mclk) disable iff (!rst_b) // see [R07]
        s_start_wait |=> state_r == nftf_pkg::NFTF_WAIT && dcount_r == 32'h0)
        else $error("delay wait not started");
    a_size_limit: assert property (@(posedge mclk) disable iff (!rst_b) // see [R11]
        size_r <= `NFTF_BUFSIZE_MAX)
        else $error("buffer size above range");
    a_overrun_sticky: assert property (@(posedge mclk) disable iff (!rst_b) // see [R23]
        rx_overrun |=> overrun_r)
        else $error("overrun flag not set");
    a_overrun_hold: assert property (@(posedge mclk) disable iff (!rst_b) // see [R23]
        overrun_r && !rx_overrun && !(w_rxs && wdata[`NFTF_BIT_OVERRUN]) |=> overrun_r)
        else $error("overrun flag lost");
    a_crc_result: assert property (@(posedge mclk) disable iff (!rst_b) // see [R22]
        rx_frame_done && receive_check_verify |=> crc_fail_r == $past(rx_check_bad))
        else $error("check result wrong");
    a_rx_length: assert property (@(posedge mclk) disable iff (!rst_b) // see [R25]
        rx_frame_done |=> rxlen_r == {$past(rx_whole_bytes), $past(rx_leftover_bits)})
        else $error("receive length not captured");
    a_field_gated: assert property (@(posedge mclk) disable iff (!rst_b) // see [R02]
        !pins_s[0] |-> !field_word[0])
        else $error("field bit shown while not activated");
endmodule
`default_nettype wire

// [rtl/nftf_params.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef NFTF_PARAMS_SVH
`define NFTF_PARAMS_SVH
`define NFTF_OFS_LOADCTRL   12'h430
`define NFTF_OFS_FIELD      12'h43C
`define NFTF_OFS_RXSTAT     12'h40C
`define NFTF_OFS_DLYMIN     12'h504
`define NFTF_OFS_DLYMAX     12'h508
`define NFTF_OFS_DLYMODE    12'h50C
`define NFTF_OFS_PTR        12'h510
`define NFTF_OFS_BUFSIZE    12'h514
`define NFTF_OFS_TXOPT      12'h518
`define NFTF_OFS_TXLEN      12'h51C
`define NFTF_OFS_RXOPT      12'h520
`define NFTF_OFS_RXLEN      12'h524
`define NFTF_OFS_IDFINAL    12'h590
`define NFTF_OFS_IDMID      12'h594
`define NFTF_OFS_IDLEN      12'h5A0
`define NFTF_OFS_CTRL       12'h600
`define NFTF_RST_DLYMIN     32'h00000480
`define NFTF_RST_DLYMAX     32'h00001000
`define NFTF_RST_DLYMODE    2'h1
`define NFTF_RST_TXOPT      5'h17
`define NFTF_RST_RXOPT      5'h15
`define NFTF_RST_IDFINAL    32'h00006363
`define NFTF_BUFSIZE_MAX    9'h101
`define NFTF_BIT_PARITY     0
`define NFTF_BIT_DROPSIDE   1
`define NFTF_BIT_SOF        2
`define NFTF_BIT_CHECK      4
`define NFTF_BIT_CRCFAIL    0
`define NFTF_BIT_OVERRUN    2
`define NFTF_BIT_GRID       8'h80
`endif

// [rtl/nftf_pkg.sv]
// Types shared by the frame timing block
package nftf_pkg;
    typedef enum logic [1:0] {
        NFTF_IMMEDIATE_SEND   = 2'h0,
        NFTF_WINDOW_SEND      = 2'h1,
        NFTF_SEND_AT_MAXIMUM  = 2'h2,
        NFTF_SEND_ON_BIT_GRID = 2'h3
    } nftf_mode_t;
    typedef enum logic [2:0] {
        NFTF_IDLE  = 3'h1,
        NFTF_WAIT  = 3'h2,
        NFTF_SEND  = 3'h4
    } nftf_state_t;
endpackage

// [rtl/nftf_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module nftf_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            meta_r <= '0;
            dout   <= '0;
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule
`default_nettype wire

// [verification/nftf_reader_model.sv]
// Remote reader model: carrier clock within frames, field and lock levels
`timescale 1ns/1ps
`default_nettype none
module nftf_reader_model #(
    parameter real HALF = 200.0
) (
    input  wire logic run,
    input  wire logic field_on,
    input  wire logic lock_on,
    output logic      carrier_clk,
    output logic      field_pin,
    output logic      lock_pin
);
    // Carrier stands still low between frames, phase unrelated to mclk
    initial
    begin
        carrier_clk = 1'b0;
        #7.3;
        forever
        begin
            #HALF;
            carrier_clk = run ? ~carrier_clk : 1'b0;
        end
    end
    assign field_pin = field_on;
    assign lock_pin  = lock_on;
endmodule
`default_nettype wire

// [verification/tb_nftf_frame_timing.sv]
// Self-checking bench for the frame timing block
`timescale 1ns/1ps
`default_nettype none
module tb_nftf_frame_timing;
    logic        mclk, rst_b, wr_stb, rd_stb, run, field_on, lock_on, activated;
    logic        start, rx_done, rx_bad, rx_ovr, tx_go, delay_timeout;
    logic        carrier_clk, field_pin, lock_pin, tx_add_parity, drop_side, tx_add_sof;
    logic        check_append, rx_parity, rx_sof, check_verify;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, seed, r, frame_buffer_pointer;
    logic [4:0]  load_control_in;
    logic [8:0]  rx_bytes, frame_buffer_size;
    logic [2:0]  rx_bits;
    logic [1:0]  tag_id_length;
    logic [31:0] mdl [int];
    int          error_cnt, total_checks, ccnt, n, c;
    int          all [16] = '{'h430, 'h43C, 'h40C, 'h504, 'h508, 'h50C, 'h510, 'h514,
                              'h518, 'h51C, 'h520, 'h524, 'h590, 'h594, 'h5A0, 'h700};
    int          rw [11] = '{'h504, 'h508, 'h50C, 'h510, 'h514, 'h518, 'h51C, 'h520,
                             'h590, 'h594, 'h5A0};
    int          tmd [6] = '{0, 1, 2, 3, 1, 3};
    int          tmn [6] = '{4, 4, 4, 4, 20, 130};
    int          tmx [6] = '{10, 10, 10, 300, 6, 200};

    nftf_frame_timing u_nftf_frame_timing (
        .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .carrier_clk(carrier_clk), .field_pin(field_pin),
        .lock_pin(lock_pin), .activated(activated), .load_control_in(load_control_in),
        .transmit_start_task(start), .rx_frame_done(rx_done), .rx_whole_bytes(rx_bytes),
        .rx_leftover_bits(rx_bits), .rx_check_bad(rx_bad), .rx_overrun(rx_ovr),
        .tx_go(tx_go), .delay_timeout(delay_timeout), .tx_add_parity(tx_add_parity),
        .unused_bit_drop_side(drop_side), .tx_add_sof(tx_add_sof),
        .transmit_check_append(check_append), .rx_expect_parity(rx_parity),
        .rx_expect_sof(rx_sof), .receive_check_verify(check_verify),
        .tag_id_length(tag_id_length), .frame_buffer_pointer(frame_buffer_pointer),
        .frame_buffer_size(frame_buffer_size)
    );
    nftf_reader_model u_nftf_reader_model (
        .run(run), .field_on(field_on), .lock_on(lock_on), .carrier_clk(carrier_clk),
        .field_pin(field_pin), .lock_pin(lock_pin)
    );

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge carrier_clk) ccnt++;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Register model: masks, saturation and write-one-to-clear
    function automatic void mdl_wr(input int a, input logic [31:0] d);
        case (a)
            'h504, 'h508, 'h510, 'h590: mdl[a] = d;
            'h50C: mdl[a] = d & 32'h3;
            'h514: mdl[a] = (d > 32'h101) ? 32'h101 : d;
            'h518: mdl[a] = d & 32'h17;
            'h51C: mdl[a] = d & 32'hFFF;
            'h520: mdl[a] = d & 32'h15;
            'h594: mdl[a] = d & 32'hFFFFFF;
            'h5A0: mdl[a] = ((d & 32'h3) == 32'h3) ? 32'h2 : d & 32'h3;
            'h40C: mdl[a] = mdl[a] & ~d;
            default: ;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        mdl_wr(a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task automatic cfg_chk;
        chk(tx_add_parity, mdl['h518][0]);
        chk(drop_side, mdl['h518][1]);
        chk(tx_add_sof, mdl['h518][2]);
        chk(check_append, mdl['h518][4]);
        chk(rx_parity, mdl['h520][0]);
        chk(rx_sof, mdl['h520][2]);
        chk(check_verify, mdl['h520][4]);
        chk(frame_buffer_pointer, mdl['h510]);
        chk(frame_buffer_size, mdl['h514]);
        chk(tag_id_length, mdl['h5A0]);
    endtask

    task automatic dly(input int md, input int mn, input int mx);
        wr(12'h504, mn);
        wr(12'h508, mx);
        wr(12'h50C, md);
        ccnt = 0;
        @(posedge mclk);
        start <= 1'b1;
        run   <= (md != 0);
        @(posedge mclk);
        start <= 1'b0;
        #1;
        n = 0;
        while (tx_go !== 1'b1 && delay_timeout !== 1'b1 && n < 4000)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 4000)
        begin
            error_cnt++;
            end_of_test;
        end
        c = (md == 2) ? mx : (md == 3) ? (mn + 127) / 128 * 128 : mn;
        chk(tx_go, (md == 0) || (c <= mx));
        chk(delay_timeout, (md != 0) && (c > mx));
        // A missed window times out on the first carrier tick past the maximum
        chk(ccnt, (md == 0) ? 0 : (c <= mx) ? c : mx + 1);
        if (md == 0) chk(n, 0);
        run <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(12'h600, 32'(nftf_pkg::NFTF_IDLE));
    endtask

    task automatic rxf(input logic [8:0] by, input logic [2:0] bi, input logic bad,
                       input logic ovr);
        @(posedge mclk);
        rx_done  <= 1'b1;
        rx_bytes <= by;
        rx_bits  <= bi;
        rx_bad   <= bad;
        rx_ovr   <= ovr;
        @(posedge mclk);
        rx_done <= 1'b0;
        rx_ovr  <= 1'b0;
        mdl['h524] = {20'h0, by, bi};
        if (mdl['h520][4]) mdl['h40C][0] = bad;
        if (ovr) mdl['h40C][2] = 1'b1;
        rd(12'h524, mdl['h524]);
        rd(12'h40C, mdl['h40C]);
    endtask

    initial
    begin
        rst_b = 1'b0;
        {wr_stb, rd_stb, run, field_on, lock_on, activated} = '0;
        {start, rx_done, rx_bad, rx_ovr} = '0;
        addr = '0;
        wdata = '0;
        load_control_in = '0;
        rx_bytes = '0;
        rx_bits = '0;
        seed = 32'h0000000F;
        ccnt = 0;
        foreach (all[i]) mdl[all[i]] = 32'h0;
        mdl['h504] = 32'h00000480;
        mdl['h508] = 32'h00001000;
        mdl['h50C] = 32'h00000001;
        mdl['h518] = 32'h00000017;
        mdl['h520] = 32'h00000015;
        mdl['h590] = 32'h00006363;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (all[i]) rd(12'(all[i]), mdl[all[i]]);
        cfg_chk;
        repeat (2)
        begin
            foreach (rw[i])
            begin
                wr(12'(rw[i]), rnd());
                rd(12'(rw[i]), mdl[rw[i]]);
            end
            cfg_chk;
        end
        foreach (all[i])
        begin
            wr(12'(all[i]), rnd() & 32'hFFFFFFFA);
            rd(12'(all[i]), mdl[all[i]]);
        end
        for (int k = 256; k < 259; k++)
        begin
            wr(12'h514, k);
            rd(12'h514, mdl['h514]);
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(12'h5A0, k);
            rd(12'h5A0, mdl['h5A0]);
            chk(tag_id_length, mdl['h5A0]);
        end
        repeat (3)
        begin
            r = rnd();
            @(posedge mclk);
            load_control_in <= r[4:0];
            mdl['h430] = {27'h0, r[4:0]};
            rd(12'h430, mdl['h430]);
        end
        for (int k = 0; k < 8; k++)
        begin
            @(posedge mclk);
            {activated, field_on, lock_on} <= k[2:0];
            repeat (4) @(posedge mclk);
            mdl['h43C] = {30'h0, lock_on, field_on & activated};
            rd(12'h43C, mdl['h43C]);
        end
        foreach (tmd[i]) dly(tmd[i], tmn[i], tmx[i]);
        repeat (8)
        begin
            wr(12'h520, rnd());
            r = rnd();
            rxf(9'(r % 258), r[14:12], r[20], r[21]);
            wr(12'h40C, rnd() & 32'h5);
            rd(12'h40C, mdl['h40C]);
            cfg_chk;
        end
        end_of_test;
    end
endmodule
`default_nettype wire
